// >>> hw/pmmp_pkg.sv
// pmmp_pkg: constants and types shared by the mii/rmii link ends
// assumes a single 100 MHz system clock on both ends
package pmmp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int MII_FAST_MHZ = 25;
  localparam int MII_SLOW_KHZ = 2500;
  localparam int RMII_REF_MHZ = 50;
  localparam int MDC_RUN_MHZ = 10;
  localparam int HALF_W = 5;
  // half periods of the link clocks in system cycles
  localparam logic [HALF_W-1:0] MII_HALF_FAST = HALF_W'(CLK_MHZ / (2 * MII_FAST_MHZ));
  localparam logic [HALF_W-1:0] MII_HALF_SLOW = HALF_W'(CLK_MHZ * 1000 / (2 * MII_SLOW_KHZ));
  localparam logic [HALF_W-1:0] REF_HALF_RMII = HALF_W'(CLK_MHZ / (2 * RMII_REF_MHZ));
  localparam logic [HALF_W-1:0] REF_HALF_MII = MII_HALF_FAST;
  localparam logic [HALF_W-1:0] MDC_HALF = HALF_W'(CLK_MHZ / (2 * MDC_RUN_MHZ));
  // heartbeat pulse length
  localparam int SQE_NS = 1000;
  localparam int SQE_W = 7;
  localparam logic [SQE_W-1:0] SQE_CYC = SQE_W'(SQE_NS * CLK_MHZ / 1000);
  // receive error substitutes
  localparam logic [3:0] RX_ERR_NIB = 4'he;
  localparam logic [1:0] RMII_ERR_DIBIT = 2'h1;
  // strap level that selects rmii
  localparam logic STRAP_RMII_LVL = 1'b1;
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // management exchange
  localparam int MG_BITS = 16;
  localparam int MG_CNT_W = 5;
  localparam logic [MG_CNT_W-1:0] MG_LAST = MG_CNT_W'(MG_BITS - 1);
  localparam logic [MG_CNT_W-1:0] MG_END = MG_CNT_W'(MG_BITS);
  typedef enum logic {MG_LISTEN, MG_REPLY} pmmp_dmg_e;
  typedef enum logic [1:0] {MM_IDLE, MM_SEND, MM_RECV} pmmp_mmg_e;
endpackage : pmmp_pkg

// >>> hw/pmmp_if.sv
// pmmp_if: pins between the phy end and the mac end
// assumes a testbench supplies the rx_dv strap level
`timescale 1ns/1ps
interface pmmp_if;
  logic tx_clk;
  logic tx_en;
  logic [3:0] txd;
  logic rx_clk;
  logic rx_dv;
  logic rx_dv_oe;
  logic rx_dv_strap;
  logic rx_dv_pin;
  logic rx_er;
  logic [3:0] rxd;
  logic crs;
  logic col;
  logic ref_clk;
  logic mdc;
  logic mdio_dev_o;
  logic mdio_dev_oe;
  logic mdio_mac_o;
  logic mdio_mac_oe;
  logic mdio;
  // strap resistor shows while the phy does not drive
  assign rx_dv_pin = rx_dv_oe ? rx_dv : rx_dv_strap;
  // open line with pullup
  assign mdio = (~mdio_dev_oe | mdio_dev_o) & (~mdio_mac_oe | mdio_mac_o);
  modport dev (output tx_clk, rx_clk, rx_dv, rx_dv_oe, rx_er, rxd, crs, col, mdio_dev_o, mdio_dev_oe,
    input tx_en, txd, rx_dv_pin, ref_clk, mdc, mdio);
  modport mac (input tx_clk, rx_clk, rx_dv_pin, rx_er, rxd, crs, col, mdio,
    output tx_en, txd, ref_clk, mdc, mdio_mac_o, mdio_mac_oe);
endinterface : pmmp_if

// >>> hw/pmmp_clk_div.sv
// pmmp_clk_div: square wave of programmable half period
// assumes half is at least one
`timescale 1ns/1ps
module pmmp_clk_div
  import pmmp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [HALF_W-1:0] half,
  output logic clk_o
);
  logic [HALF_W-1:0] cnt_r;
  // count half periods, hold low while stopped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      clk_o <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      clk_o <= 1'b0;
    end else if (cnt_r >= half - 1'b1) begin // also recovers when half shrinks
      cnt_r <= '0;
      clk_o <= ~clk_o;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule : pmmp_clk_div

// >>> hw/pmmp_phy_end.sv
// pmmp_phy_end: phy side of the mii/rmii mac data port
// assumes line side logic and the mac end run on clk_sys
`timescale 1ns/1ps
// Behaviour
// - mii tx_clk 25 or 2.5 MHz
// - rmii: link clocks idle, use reference
// - mac holds tx_en with valid nibble
// - mac holds tx_en with valid dibit
// - mii nibble taken on tx_clk
// - rmii dibit taken on reference clock
// - mii rx_clk 25 or 2.5 MHz
// - rx_dv marks data; strap defaults mii
// - rmii rx_dv ignores carrier
// - mii rx_er on bad symbol, 100M
// - rmii rx_er on bad symbol with crs_dv, 100M only
// - errors corrupt delivered receive data
// - mii rxd driven on rx_clk
// - rmii two rxd bits on reference
// - mii crs while medium busy
// - rmii crs_dv merges carrier and valid
// - half duplex col on tx and rx
// - 10M heartbeat pulses col 1 us
// - full duplex col stays low
// - rmii mac derives collision itself
// - mdc at most 25 MHz, asynchronous
// - mdio driven only in own part
// - strap sampled at reset sets mode
module pmmp_phy_end
  import pmmp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  pmmp_if.dev link,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic heartbeat_en,
  input wire logic line_rx_dv,
  input wire logic [3:0] line_rx_nib,
  input wire logic line_rx_err,
  input wire logic line_busy,
  output logic line_rx_take,
  output logic line_tx_valid,
  output logic [3:0] line_tx_nib,
  output logic rmii_mode,
  output logic mgmt_cmd_valid,
  output logic [15:0] mgmt_cmd,
  input wire logic [15:0] mgmt_reply
);
  logic strap_s1_r;
  logic strap_s2_r;
  logic strap_done_r;
  logic [1:0] strap_cnt_r;
  logic mii_clk;
  logic mii_prev_r;
  logic ref_prev_r;
  logic cap_tick;
  logic drv_tick;
  logic tx_ph_r;
  logic [1:0] tx_low_r;
  logic tx_act_r;
  logic rx_ph_r;
  logic [SQE_W-1:0] sqe_r;
  logic mdc_s1_r;
  logic mdc_s2_r;
  logic mdc_prev_r;
  logic mdio_s1_r;
  logic mdio_s2_r;
  logic mdc_rise;
  logic mdc_fall;
  pmmp_dmg_e mg_st_r;
  logic [MG_CNT_W-1:0] mg_cnt_r;
  logic [15:0] mg_sh_r;

  ////////////////////////////////////////////////////////////////////
  // strap capture
  ////////////////////////////////////////////////////////////////////
  // two flops on the strap pin
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
    end else begin
      strap_s1_r <= link.rx_dv_pin;
      strap_s2_r <= strap_s1_r;
    end
  end

  // latch mode once after release, pin still undriven
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt_r <= '0;
      strap_done_r <= 1'b0;
      rmii_mode <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 1'b1;
      if (strap_cnt_r == STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        rmii_mode <= (strap_s2_r == STRAP_RMII_LVL);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link timing
  ////////////////////////////////////////////////////////////////////
  // mii clock, stopped in rmii
  pmmp_clk_div u_mii_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run(strap_done_r & ~rmii_mode),
    .half(speed_100 ? MII_HALF_FAST : MII_HALF_SLOW),
    .clk_o(mii_clk)
  );

  assign link.tx_clk = mii_clk;
  assign link.rx_clk = mii_clk;

  // previous clock levels for edge finding
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mii_prev_r <= 1'b0;
      ref_prev_r <= 1'b0;
    end else begin
      mii_prev_r <= mii_clk;
      ref_prev_r <= link.ref_clk;
    end
  end

  // sample on rising edges, drive on falling edges
  assign cap_tick = strap_done_r & (rmii_mode ? (link.ref_clk & ~ref_prev_r) : (mii_clk & ~mii_prev_r));
  assign drv_tick = strap_done_r & (rmii_mode ? (~link.ref_clk & ref_prev_r) : (~mii_clk & mii_prev_r));

  ////////////////////////////////////////////////////////////////////
  // transmit capture
  ////////////////////////////////////////////////////////////////////
  // nibble or two dibits, low pair first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      line_tx_valid <= 1'b0;
      line_tx_nib <= '0;
      tx_ph_r <= 1'b0;
      tx_low_r <= '0;
      tx_act_r <= 1'b0;
    end else begin
      line_tx_valid <= 1'b0;
      if (cap_tick) begin
        tx_act_r <= link.tx_en;
        if (!link.tx_en) begin
          tx_ph_r <= 1'b0;
        end else if (!rmii_mode) begin
          line_tx_valid <= 1'b1;
          line_tx_nib <= link.txd;
        end else if (!tx_ph_r) begin
          tx_low_r <= link.txd[1:0];
          tx_ph_r <= 1'b1;
        end else begin
          line_tx_valid <= 1'b1;
          line_tx_nib <= {link.txd[1:0], tx_low_r};
          tx_ph_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive drive
  ////////////////////////////////////////////////////////////////////
  // present line nibbles, corrupting on error
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link.rx_dv <= 1'b0;
      link.rxd <= '0;
      link.rx_er <= 1'b0;
      line_rx_take <= 1'b0;
      rx_ph_r <= 1'b0;
    end else begin
      line_rx_take <= 1'b0;
      if (drv_tick) begin
        link.rx_dv <= line_rx_dv;
        if (!rmii_mode) begin
          link.rxd <= line_rx_err ? RX_ERR_NIB : line_rx_nib;
          link.rx_er <= speed_100 & line_rx_dv & line_rx_err;
          line_rx_take <= line_rx_dv;
        end else begin
          link.rx_er <= speed_100 & line_err_crs(line_rx_err, line_busy | line_rx_dv);
          if (line_rx_err) begin
            link.rxd <= {2'h0, RMII_ERR_DIBIT};
          end else begin
            link.rxd <= {2'h0, rx_ph_r ? line_rx_nib[3:2] : line_rx_nib[1:0]};
          end
          if (!line_rx_dv) begin
            rx_ph_r <= 1'b0;
          end else begin
            rx_ph_r <= ~rx_ph_r;
            line_rx_take <= rx_ph_r;
          end
        end
      end
    end
  end

  function automatic logic line_err_crs(input logic err, input logic crs_dv);
    line_err_crs = err & crs_dv;
  endfunction : line_err_crs

  ////////////////////////////////////////////////////////////////////
  // carrier, collision, heartbeat
  ////////////////////////////////////////////////////////////////////
  // heartbeat window after each 10M half duplex mii transmission
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sqe_r <= '0;
    end else if (cap_tick & tx_act_r & ~link.tx_en & ~rmii_mode & ~speed_100 & ~full_duplex & heartbeat_en) begin
      sqe_r <= SQE_CYC;
    end else if (sqe_r != '0) begin
      sqe_r <= sqe_r - 1'b1;
    end
  end

  // crs or crs_dv, and col
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link.crs <= 1'b0;
      link.col <= 1'b0;
    end else if (!strap_done_r) begin
      link.crs <= 1'b0;
      link.col <= 1'b0;
    end else if (rmii_mode) begin
      link.crs <= line_busy | line_rx_dv;
      link.col <= 1'b0;
    end else begin
      link.crs <= line_busy | (tx_act_r & ~full_duplex);
      link.col <= ~full_duplex & ((tx_act_r & line_busy) | (sqe_r != '0));
    end
  end

  // release the strap pin only after capture
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link.rx_dv_oe <= 1'b0;
    end else begin
      link.rx_dv_oe <= strap_done_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // management pins
  ////////////////////////////////////////////////////////////////////
  // mdc and mdio are asynchronous, two flops each
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mdc_s1_r <= 1'b0;
      mdc_s2_r <= 1'b0;
      mdc_prev_r <= 1'b0;
      mdio_s1_r <= 1'b1;
      mdio_s2_r <= 1'b1;
    end else begin
      mdc_s1_r <= link.mdc;
      mdc_s2_r <= mdc_s1_r;
      mdc_prev_r <= mdc_s2_r;
      mdio_s1_r <= link.mdio;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  assign mdc_rise = mdc_s2_r & ~mdc_prev_r;
  assign mdc_fall = ~mdc_s2_r & mdc_prev_r;

  // listen to sixteen bits, then answer sixteen bits
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mg_st_r <= MG_LISTEN;
      mg_cnt_r <= '0;
      mg_sh_r <= '0;
      mgmt_cmd <= '0;
      mgmt_cmd_valid <= 1'b0;
      link.mdio_dev_o <= 1'b1;
      link.mdio_dev_oe <= 1'b0;
    end else begin
      mgmt_cmd_valid <= 1'b0;
      unique case (mg_st_r)
        MG_LISTEN: begin
          if (mdc_rise) begin
            mg_sh_r <= {mg_sh_r[14:0], mdio_s2_r};
            mg_cnt_r <= mg_cnt_r + 1'b1;
            if (mg_cnt_r == MG_LAST) begin
              mgmt_cmd <= {mg_sh_r[14:0], mdio_s2_r};
              mgmt_cmd_valid <= 1'b1;
              mg_sh_r <= mgmt_reply;
              mg_cnt_r <= '0;
              mg_st_r <= MG_REPLY;
            end
          end
        end
        MG_REPLY: begin
          if (mdc_fall) begin
            if (mg_cnt_r == MG_END) begin
              link.mdio_dev_oe <= 1'b0;
              link.mdio_dev_o <= 1'b1;
              mg_cnt_r <= '0;
              mg_st_r <= MG_LISTEN;
            end else begin
              link.mdio_dev_oe <= 1'b1;
              link.mdio_dev_o <= mg_sh_r[15];
              mg_sh_r <= {mg_sh_r[14:0], 1'b0};
              mg_cnt_r <= mg_cnt_r + 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule : pmmp_phy_end

// >>> hw/pmmp_mac_end.sv
// pmmp_mac_end: mac side of the mii/rmii data port
// assumes the phy end runs on the same clk_sys
`timescale 1ns/1ps
module pmmp_mac_end
  import pmmp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  pmmp_if.mac link,
  input wire logic rmii_mode,
  input wire logic user_tx_valid,
  input wire logic [3:0] user_tx_nib,
  output logic user_tx_take,
  output logic user_rx_valid,
  output logic [3:0] user_rx_nib,
  output logic user_rx_err,
  output logic user_crs,
  output logic user_col,
  input wire logic mgmt_go,
  input wire logic [15:0] mgmt_word,
  output logic mgmt_busy,
  output logic mgmt_done,
  output logic [15:0] mgmt_rdata
);
  logic tck;
  logic rck;
  logic tck_prev_r;
  logic rck_prev_r;
  logic tx_ph_r;
  logic [1:0] tx_hi_r;
  logic rx_ph_r;
  logic [1:0] rx_low_r;
  logic mdc_prev_r;
  pmmp_mmg_e mm_st_r;
  logic [MG_CNT_W-1:0] mm_cnt_r;
  logic [15:0] mm_sh_r;

  ////////////////////////////////////////////////////////////////////
  // clocks
  ////////////////////////////////////////////////////////////////////
  // reference clock, 50 MHz in rmii
  pmmp_clk_div u_ref_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run(1'b1),
    .half(rmii_mode ? REF_HALF_RMII : REF_HALF_MII),
    .clk_o(link.ref_clk)
  );

  // mdc well under its ceiling, only during exchanges
  pmmp_clk_div u_mdc_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run(mm_st_r != MM_IDLE),
    .half(MDC_HALF),
    .clk_o(link.mdc)
  );

  assign tck = rmii_mode ? link.ref_clk : link.tx_clk;
  assign rck = rmii_mode ? link.ref_clk : link.rx_clk;

  // previous clock levels
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tck_prev_r <= 1'b0;
      rck_prev_r <= 1'b0;
      mdc_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= tck;
      rck_prev_r <= rck;
      mdc_prev_r <= link.mdc;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmit
  ////////////////////////////////////////////////////////////////////
  // update on falling edge so phy samples stable data
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link.tx_en <= 1'b0;
      link.txd <= '0;
      user_tx_take <= 1'b0;
      tx_ph_r <= 1'b0;
      tx_hi_r <= '0;
    end else begin
      user_tx_take <= 1'b0;
      if (~tck & tck_prev_r) begin
        if (rmii_mode & tx_ph_r) begin
          link.txd <= {2'h0, tx_hi_r};
          tx_ph_r <= 1'b0;
        end else if (user_tx_valid) begin
          link.tx_en <= 1'b1;
          link.txd <= rmii_mode ? {2'h0, user_tx_nib[1:0]} : user_tx_nib;
          tx_hi_r <= user_tx_nib[3:2];
          tx_ph_r <= rmii_mode;
          user_tx_take <= 1'b1;
        end else begin
          link.tx_en <= 1'b0;
          link.txd <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive
  ////////////////////////////////////////////////////////////////////
  // sample on rising edge, pair rmii dibits
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      user_rx_valid <= 1'b0;
      user_rx_nib <= '0;
      user_rx_err <= 1'b0;
      rx_ph_r <= 1'b0;
      rx_low_r <= '0;
    end else begin
      user_rx_valid <= 1'b0;
      if (rck & ~rck_prev_r) begin
        if (!link.rx_dv_pin) begin
          rx_ph_r <= 1'b0;
        end else if (!rmii_mode) begin
          user_rx_valid <= 1'b1;
          user_rx_nib <= link.rxd;
          user_rx_err <= link.rx_er;
        end else if (!rx_ph_r) begin
          rx_low_r <= link.rxd[1:0];
          user_rx_err <= link.rx_er;
          rx_ph_r <= 1'b1;
        end else begin
          user_rx_valid <= 1'b1;
          user_rx_nib <= {link.rxd[1:0], rx_low_r};
          user_rx_err <= user_rx_err | link.rx_er;
          rx_ph_r <= 1'b0;
        end
      end
    end
  end

  // carrier and collision, rmii collision from crs_dv and tx_en
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      user_crs <= 1'b0;
      user_col <= 1'b0;
    end else begin
      user_crs <= link.crs;
      user_col <= rmii_mode ? (link.crs & link.tx_en) : link.col;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // management
  ////////////////////////////////////////////////////////////////////
  // send sixteen bits, release, read sixteen bits
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mm_st_r <= MM_IDLE;
      mm_cnt_r <= '0;
      mm_sh_r <= '0;
      mgmt_busy <= 1'b0;
      mgmt_done <= 1'b0;
      mgmt_rdata <= '0;
      link.mdio_mac_o <= 1'b1;
      link.mdio_mac_oe <= 1'b0;
    end else begin
      mgmt_done <= 1'b0;
      unique case (mm_st_r)
        MM_IDLE: begin
          if (mgmt_go) begin
            link.mdio_mac_oe <= 1'b1;
            link.mdio_mac_o <= mgmt_word[15];
            mm_sh_r <= {mgmt_word[14:0], 1'b0};
            mm_cnt_r <= '0;
            mgmt_busy <= 1'b1;
            mm_st_r <= MM_SEND;
          end
        end
        MM_SEND: begin
          if (link.mdc & ~mdc_prev_r) begin
            mm_cnt_r <= mm_cnt_r + 1'b1;
          end else if (~link.mdc & mdc_prev_r) begin
            if (mm_cnt_r == MG_END) begin
              link.mdio_mac_oe <= 1'b0;
              link.mdio_mac_o <= 1'b1;
              mm_cnt_r <= '0;
              mm_st_r <= MM_RECV;
            end else begin
              link.mdio_mac_o <= mm_sh_r[15];
              mm_sh_r <= {mm_sh_r[14:0], 1'b0};
            end
          end
        end
        MM_RECV: begin
          if (link.mdc & ~mdc_prev_r) begin
            mm_sh_r <= {mm_sh_r[14:0], link.mdio};
            mm_cnt_r <= mm_cnt_r + 1'b1;
            if (mm_cnt_r == MG_LAST) begin
              mgmt_rdata <= {mm_sh_r[14:0], link.mdio};
              mgmt_done <= 1'b1;
              mgmt_busy <= 1'b0;
              mm_st_r <= MM_IDLE;
            end
          end
        end
        default: begin
          mm_st_r <= MM_IDLE;
        end
      endcase
    end
  end
endmodule : pmmp_mac_end

// >>> dv/pmmp_asserts.sv
// pmmp_asserts: timing checks on the pins between the phy end and the mac end
// assumes one clk_sys domain and the async active-low rst_b of both ends
`timescale 1ns/1ps
module pmmp_asserts
  import pmmp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [3:0] rxd,
  input wire logic crs,
  input wire logic mdc,
  input wire logic mdio_dev_oe,
  input wire logic mdio_mac_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  // link clocks: pairing, shortest high phase, bounded phases
  rxclk_fall_a: assert property ($rose(rx_clk) |-> ##[1:20] $fell(rx_clk))
    else $error("receive clock high phase too long");
  clk_high_a: assert property ($rose(tx_clk) |-> tx_clk [*2])
    else $error("transmit clock high phase too short");
  clk_fall_a: assert property ($rose(tx_clk) |-> ##[1:20] $fell(tx_clk))
    else $error("transmit clock high phase too long");
  clk_rise_a: assert property ($fell(tx_clk) |-> ##[1:20] $rose(tx_clk))
    else $error("transmit clock low phase too long");
  // data launched away from the sampling phase
  txd_edge_a: assert property ($changed(txd) |-> !tx_clk)
    else $error("transmit data moved while clock high");
  rxd_edge_a: assert property ($changed(rxd) |-> !rx_clk)
    else $error("receive data moved while clock high");
  // mac idles the data lines whenever enable is low
  txen_idle_a: assert property (!tx_en |-> txd == 4'h0)
    else $error("transmit data active without enable");
  // receive errors: framing and data corruption
  err_frame_a: assert property (rx_er |-> (rx_dv || crs))
    else $error("receive error outside a frame");
  err_data_a: assert property (rx_er |-> (rxd == RX_ERR_NIB || rxd == {2'h0, RMII_ERR_DIBIT}))
    else $error("receive error without corrupted data");
  // management line
  mdc_high_a: assert property ($rose(mdc) |-> mdc [*2])
    else $error("management clock too fast");
  mdio_one_a: assert property (!(mdio_dev_oe && mdio_mac_oe))
    else $error("both ends drive the management line");
endmodule : pmmp_asserts

// >>> dv/pmmp_test.sv
// pmmp_test: both link ends joined by one interface, random traffic both ways
// assumes the design package and interface are compiled first
`timescale 1ns/1ps
module pmmp_test
  import pmmp_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic spd = 1'b1, fdx = 1'b0, hbe = 1'b0, mode = 1'b0;
  logic l_dv = 1'b0, l_err = 1'b0, l_busy = 1'b0, u_val = 1'b0, go = 1'b0;
  logic [3:0] l_nib = 4'h0, u_nib = 4'h0;
  logic [15:0] word = 16'h0, reply = 16'h0, lf = 16'h2e32, cmd_seen;
  logic l_take, l_tval, rmii, cmd_v, u_take, ur_val, ur_err, u_crs, u_col, busy, done;
  logic [3:0] l_tnib, ur_nib;
  logic [15:0] cmd, rdata;
  logic [4:0] txq[$], txe[$], rxq[$], rxe[$];
  int n_errors = 0, total_checks = 0, cyc = 0, ncol = 0, ucol = 0, ncrs = 0, ntxc = 0;
  ////////////////////////////////////////////////////////////
  // clock and the two ends
  always #5 clk_sys = ~clk_sys;
  pmmp_if lnk();
  pmmp_phy_end pmmp_phy_end_inst(.clk_sys(clk_sys), .rst_b(rst_b), .link(lnk.dev), .speed_100(spd),
    .full_duplex(fdx), .heartbeat_en(hbe), .line_rx_dv(l_dv), .line_rx_nib(l_nib), .line_rx_err(l_err),
    .line_busy(l_busy), .line_rx_take(l_take), .line_tx_valid(l_tval), .line_tx_nib(l_tnib),
    .rmii_mode(rmii), .mgmt_cmd_valid(cmd_v), .mgmt_cmd(cmd), .mgmt_reply(reply));
  pmmp_mac_end pmmp_mac_end_inst(.clk_sys(clk_sys), .rst_b(rst_b), .link(lnk.mac), .rmii_mode(rmii),
    .user_tx_valid(u_val), .user_tx_nib(u_nib), .user_tx_take(u_take), .user_rx_valid(ur_val),
    .user_rx_nib(ur_nib), .user_rx_err(ur_err), .user_crs(u_crs), .user_col(u_col), .mgmt_go(go),
    .mgmt_word(word), .mgmt_busy(busy), .mgmt_done(done), .mgmt_rdata(rdata));
  pmmp_asserts pmmp_asserts_inst(.clk_sys(clk_sys), .rst_b(rst_b), .tx_clk(lnk.tx_clk), .rx_clk(lnk.rx_clk),
    .txd(lnk.txd), .rx_dv(lnk.rx_dv), .rx_er(lnk.rx_er), .rxd(lnk.rxd), .crs(lnk.crs), .mdc(lnk.mdc),
    .mdio_dev_oe(lnk.mdio_dev_oe), .mdio_mac_oe(lnk.mdio_mac_oe), .tx_en(lnk.tx_en));
  ////////////////////////////////////////////////////////////
  // helpers: random source, expectation, compare, finish
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd
  function automatic logic [4:0] exp_rx(logic [3:0] n, logic e);
    if (!e) return {1'b0, n};
    return {spd, mode ? {RMII_ERR_DIBIT, RMII_ERR_DIBIT} : RX_ERR_NIB};
  endfunction : exp_rx
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  ////////////////////////////////////////////////////////////
  // monitor of the phy line side and the mac user side, plus the hang limit
  always @(posedge clk_sys) begin
    cyc++;
    if (l_tval === 1'b1) txq.push_back({1'b0, l_tnib});
    if (ur_val === 1'b1) rxq.push_back({ur_err, ur_nib});
    if (cmd_v === 1'b1) cmd_seen = cmd;
    if (lnk.col === 1'b1) ncol++;
    if (u_col === 1'b1) ucol++;
    if (u_crs === 1'b1) ncrs++;
    if (lnk.tx_clk === 1'b1) ntxc++;
    if (cyc == 8000) begin
      n_errors++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////
  // drivers: user transmit nibbles, line receive nibbles
  task automatic send_tx(int n);
    logic [3:0] v;
    for (int i = 0; i < n; i++) begin
      v = 4'(rnd());
      u_val <= 1'b1;
      u_nib <= v;
      txe.push_back({1'b0, v});
      do @(posedge clk_sys); while (u_take !== 1'b1);
    end
    u_val <= 1'b0;
  endtask : send_tx
  task automatic send_rx(int n);
    logic [3:0] v;
    logic e;
    for (int i = 0; i < n; i++) begin
      v = 4'(rnd());
      e = (i == 1) || (lf[2:0] == 3'h0);
      l_dv <= 1'b1;
      l_busy <= 1'b1;
      l_nib <= v;
      l_err <= e;
      rxe.push_back(exp_rx(v, e));
      do @(posedge clk_sys); while (l_take !== 1'b1);
    end
    // carrier lingers without data: nothing more may be delivered
    l_dv <= 1'b0;
    l_err <= 1'b0;
    tick(20);
    l_busy <= 1'b0;
  endtask : send_rx
  task automatic cmp_q();
    chk(16'(txq.size()), 16'(txe.size()));
    foreach (txe[i]) chk(16'(txq[i]), 16'(txe[i]));
    chk(16'(rxq.size()), 16'(rxe.size()));
    foreach (rxe[i]) chk(16'(rxq[i]), 16'(rxe[i]));
    txq.delete();
    txe.delete();
    rxq.delete();
    rxe.delete();
  endtask : cmp_q
  ////////////////////////////////////////////////////////////
  // one pass per strapped mode, each pass starts with its own reset
  task automatic run(logic s);
    int k;
    mode = s;
    lnk.rx_dv_strap <= s;
    spd <= 1'b1;
    fdx <= 1'b0;
    hbe <= 1'b0;
    rst_b <= 1'b0;
    tick(8);
    rst_b <= 1'b1;
    tick(12);
    chk(16'(rmii), 16'(s));
    ucol = 0;
    ncrs = 0;
    ntxc = 0;
    fork send_tx(8); send_rx(8); join
    tick(40);
    cmp_q();
    chk(16'(ucol > 0), 16'h1);
    chk(16'(ncrs > 0), 16'h1);
    fdx <= 1'b1;
    ncol = 0;
    fork send_tx(6); send_rx(6); join
    tick(40);
    cmp_q();
    chk(16'(ncol), 16'h0);
    spd <= 1'b0;
    fdx <= 1'b0;
    hbe <= 1'b1;
    tick(2);
    ncol = 0;
    send_tx(3);
    tick(300);
    k = (ncol >= SQE_CYC - 2 && ncol <= SQE_CYC + 2) ? 1 : 0;
    chk(16'(s ? ncol == 0 : k == 1), 16'h1);
    send_rx(3);
    tick(200);
    cmp_q();
    chk(16'(ntxc > 0), 16'(!s));
    word <= rnd();
    reply <= rnd();
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(2);
    chk(16'(busy), 16'h1);
    k = 0;
    do begin @(posedge clk_sys); k++; end while (done !== 1'b1 && k < 1000);
    chk(16'(k < 1000), 16'h1);
    chk(16'(busy), 16'h0);
    chk(cmd_seen, word);
    chk(rdata, reply);
  endtask : run
  // main sequence
  initial begin
    lnk.rx_dv_strap = 1'b0;
    run(1'b0);
    run(1'b1);
    stop_test();
  end
endmodule : pmmp_test
